// [rtl/msrp_pkg.sv]
// Constants shared by the sensor register port and its testbench
package msrp_pkg;
    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam longint CLK_HZ     = 50_000_000;
    localparam longint SLEEP_T1_S = 120;
    localparam longint SLEEP_T2_S = 300;
    localparam longint SLEEP_T3_S = 300;
    localparam longint WAKE_T1_S  = 24;
    localparam longint WAKE_T2_S  = 40;
    localparam longint WAKE_T3_S  = 32;
    localparam longint SLEEP_T1_CYC = SLEEP_T1_S * CLK_HZ;
    localparam longint SLEEP_T2_CYC = SLEEP_T2_S * CLK_HZ;
    localparam longint SLEEP_T3_CYC = SLEEP_T3_S * CLK_HZ;
    localparam longint WAKE_T1_CYC  = WAKE_T1_S * CLK_HZ;
    localparam longint WAKE_T2_CYC  = WAKE_T2_S * CLK_HZ;
    localparam longint WAKE_T3_CYC  = WAKE_T3_S * CLK_HZ;
    localparam int     TMR_W        = 34;
    // ----------------------------------------
    // Register numbers
    // ----------------------------------------
    localparam logic [15:0] IR_BASE          = 16'h7531;
    localparam logic [15:0] IR_MEDIAN        = 16'h7531;
    localparam logic [15:0] IR_MEAN          = 16'h7533;
    localparam logic [15:0] IR_SPREAD        = 16'h7535;
    localparam logic [15:0] IR_LOWEST        = 16'h7537;
    localparam logic [15:0] IR_HIGHEST       = 16'h7539;
    localparam logic [15:0] IR_AVG_TEMP      = 16'h753B;
    localparam logic [15:0] IR_ERROR         = 16'h753D;
    localparam logic [16:0] IR_WORDS         = 17'h0000E;
    localparam logic [15:0] HR_BASE          = 16'h9C41;
    localparam logic [15:0] HR_NODE_ADDR     = 16'h9C41;
    localparam logic [15:0] HR_BURST_MODE    = 16'h9C42;
    localparam logic [15:0] HR_SAVE_KEY      = 16'h9C43;
    localparam logic [16:0] HR_WORDS         = 17'h00003;
    localparam int          RES_NUM          = 7;
    localparam logic [2:0]  RES_ERROR_IDX    = 3'h6;
    // ----------------------------------------
    // Field limits and reset values
    // ----------------------------------------
    localparam logic [15:0] NODE_MIN  = 16'h0001;
    localparam logic [15:0] NODE_MAX  = 16'h00F7;
    localparam logic [15:0] MODE_MIN  = 16'h0001;
    localparam logic [15:0] MODE_MAX  = 16'h0003;
    localparam logic [15:0] SAVE_KEY  = 16'h15B3;  // 5555 decimal
    localparam logic [7:0]  NODE_RST  = 8'h01;
    localparam logic [1:0]  MODE_RST  = 2'h1;
    localparam logic [15:0] KEY_RST   = 16'h0000;
    localparam logic [15:0] MAX_QTY   = 16'h007D;
    localparam logic [2:0]  FRAME_LEN = 3'h6;
    // ----------------------------------------
    // Function and exception codes
    // ----------------------------------------
    localparam logic [7:0] FN_RD_HOLD   = 8'h03;
    localparam logic [7:0] FN_RD_INPUT  = 8'h04;
    localparam logic [7:0] FN_WR_SINGLE = 8'h06;
    localparam logic [7:0] FN_WR_MULTI  = 8'h10;
    localparam logic [7:0] EXC_FLAG     = 8'h80;
    localparam logic [7:0] EXC_FUNC     = 8'h01;
    localparam logic [7:0] EXC_ADDR     = 8'h02;
    localparam logic [7:0] EXC_VALUE    = 8'h03;
endpackage

// [rtl/msrp_port.sv]
// Modbus register port of the turbidity sensor with its power timing
`timescale 1ns/1ns
module msrp_port
    import msrp_pkg::*;
#(
    parameter logic [TMR_W-1:0] SLEEP1_CYC = TMR_W'(SLEEP_T1_CYC),
    parameter logic [TMR_W-1:0] SLEEP2_CYC = TMR_W'(SLEEP_T2_CYC),
    parameter logic [TMR_W-1:0] SLEEP3_CYC = TMR_W'(SLEEP_T3_CYC),
    parameter logic [TMR_W-1:0] WAKE1_CYC  = TMR_W'(WAKE_T1_CYC),
    parameter logic [TMR_W-1:0] WAKE2_CYC  = TMR_W'(WAKE_T2_CYC),
    parameter logic [TMR_W-1:0] WAKE3_CYC  = TMR_W'(WAKE_T3_CYC)
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // Received frame bytes, check bytes already removed
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_last,
    // Answer frame bytes
    output logic             tx_valid,
    output logic [7:0]       tx_data,
    output logic             tx_last,
    input  wire logic        tx_ready,
    // Results from the measurement engine
    input  wire logic        meas_wr,
    input  wire logic [2:0]  meas_idx,
    input  wire logic [31:0] meas_data,
    // Operating state to the measurement engine
    output logic             low_power,
    output logic [1:0]       burst_mode
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef enum logic [1:0] {S_IDLE, S_EVAL, S_SEND} msrp_st_t;

    typedef struct packed {
        msrp_st_t                   st;
        logic [5:0][7:0]            rxb;
        logic [2:0]                 nb;
        logic [7:0]                 func;
        logic [7:0]                 exc;
        logic [7:0]                 start;
        logic [7:0]                 len;
        logic [7:0]                 idx;
        logic                       tx_valid;
        logic [7:0]                 tx_data;
        logic                       tx_last;
        logic [7:0]                 node;
        logic [1:0]                 mode;
        logic [15:0]                key;
        logic [RES_NUM-1:0][31:0]   live;
        logic [RES_NUM-1:0][31:0]   saved;
        logic                       low_power;
        logic                       stale;
        logic                       booted;
    } msrp_state_t;

    msrp_state_t s_reg;
    msrp_state_t s_next;

    logic             frame_end;
    logic             sleep_exp;
    logic             wake_exp;
    logic [TMR_W-1:0] sleep_load;
    logic [TMR_W-1:0] wake_load;

    // ----------------------------------------
    // Power timers
    // ----------------------------------------
    assign frame_end = rx_valid && rx_last;

    // Interval length follows the selected mode
    assign sleep_load = (s_reg.mode == 2'h1) ? SLEEP1_CYC :
                        (s_reg.mode == 2'h2) ? SLEEP2_CYC : SLEEP3_CYC;
    // Warm-up length follows the selected mode
    assign wake_load  = (s_reg.mode == 2'h1) ? WAKE1_CYC :
                        (s_reg.mode == 2'h2) ? WAKE2_CYC : WAKE3_CYC;

    // Any frame restarts the countdown
    msrp_timer #(.W(TMR_W)) u_sleep (
        .clk    (clk),
        .srst   (srst),
        .start  (frame_end || !s_reg.booted),
        .load   (sleep_load),
        .expire (sleep_exp)
    );

    // Warm-up after a wake frame
    msrp_timer #(.W(TMR_W)) u_wake (
        .clk    (clk),
        .srst   (srst),
        .start  (frame_end && s_reg.low_power),
        .load   (wake_load),
        .expire (wake_exp)
    );

    // ----------------------------------------
    // Answer bytes
    // ----------------------------------------
    function automatic logic [7:0] resp_byte(msrp_state_t st,
                                             logic [7:0] i);
        logic [7:0]               k;
        logic [7:0]               w;
        logic [15:0]              h;
        logic [31:0]              v;
        logic [RES_NUM-1:0][31:0] src;
        k   = i - 8'h03;
        w   = st.start + {1'b0, k[7:1]};
        h   = 16'h0000;
        src = st.stale ? st.saved : st.live;
        v   = src[w[3:1]];
        if (st.func == FN_RD_HOLD) begin
            if (w == 8'h00) h = {8'h00, st.node};
            else if (w == 8'h01) h = {14'h0000, st.mode};
            else h = st.key;
        end else begin
            // High word, then low word, each high byte first
            h = w[0] ? v[15:0] : v[31:16];
        end
        if (st.exc != 8'h00) begin
            if (i == 8'h01) resp_byte = st.func | EXC_FLAG;
            else if (i == 8'h02) resp_byte = st.exc;
            else resp_byte = st.node;
        end else if (st.func == FN_WR_SINGLE) begin
            resp_byte = (i == 8'h00) ? st.node : st.rxb[i[2:0]];
        end else if (i == 8'h00) begin
            resp_byte = st.node;
        end else if (i == 8'h01) begin
            resp_byte = st.func;
        end else if (i == 8'h02) begin
            resp_byte = st.len - 8'h03;
        end else begin
            resp_byte = k[0] ? h[7:0] : h[15:8];
        end
    endfunction

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic [15:0] a;
        logic [15:0] q;
        logic [16:0] top;
        a      = 16'h0000;
        q      = 16'h0000;
        top    = 17'h00000;
        s_next = s_reg;
        s_next.booted = 1'b1;
        // Results from the engine; error only from 30-sample bursts
        if (meas_wr && 32'(meas_idx) < RES_NUM) begin
            if (meas_idx != RES_ERROR_IDX || s_reg.mode == 2'h1) begin
                s_next.live[meas_idx] = meas_data;
            end
        end
        // Wake on any frame; saved set stays until warm-up ends
        if (frame_end && s_reg.low_power) begin
            s_next.low_power = 1'b0;
        end
        if (wake_exp) begin
            s_next.stale = 1'b0;
        end
        // Save the latest results, then sleep
        if (sleep_exp) begin
            s_next.saved     = s_reg.live;
            s_next.low_power = 1'b1;
            s_next.stale     = 1'b1;
        end
        unique case (s_reg.st)
            S_IDLE: begin
                if (rx_valid) begin
                    if (s_reg.nb < FRAME_LEN) begin
                        s_next.rxb[s_reg.nb] = rx_data;
                    end
                    if (s_reg.nb != 3'h7) begin
                        s_next.nb = s_reg.nb + 3'h1;
                    end
                    if (rx_last) begin
                        s_next.st = S_EVAL;
                    end
                end
            end
            S_EVAL: begin
                a   = {s_reg.rxb[2], s_reg.rxb[3]};
                q   = {s_reg.rxb[4], s_reg.rxb[5]};
                top = {1'b0, a} + {1'b0, q};
                s_next.func  = s_reg.rxb[1];
                s_next.exc   = 8'h00;
                s_next.start = a[7:0];
                s_next.len   = 8'h06;
                s_next.idx   = 8'h00;
                s_next.st    = S_SEND;
                s_next.nb    = 3'h0;
                if (s_reg.rxb[0] != s_reg.node || s_reg.nb < 3'h2) begin
                    s_next.st = S_IDLE;
                end else if (s_reg.rxb[1] == FN_RD_HOLD ||
                             s_reg.rxb[1] == FN_RD_INPUT) begin
                    // Reads of holding or result words
                    if (s_reg.nb != FRAME_LEN) begin
                        s_next.st = S_IDLE;
                    end else if (q == 16'h0000 || q > MAX_QTY) begin
                        s_next.exc = EXC_VALUE;
                    end else if (top > ((s_reg.rxb[1] == FN_RD_HOLD)
                                        ? HR_WORDS : IR_WORDS)) begin
                        s_next.exc = EXC_ADDR;
                    end else begin
                        s_next.len = 8'h03 + {q[6:0], 1'b0};
                    end
                end else if (s_reg.rxb[1] == FN_WR_SINGLE) begin
                    if (s_reg.nb != FRAME_LEN) begin
                        s_next.st = S_IDLE;
                    end else if (a == HR_NODE_ADDR - HR_BASE) begin
                        if (q < NODE_MIN || q > NODE_MAX) begin
                            s_next.exc = EXC_VALUE;
                        end else if (s_reg.key == SAVE_KEY) begin
                            s_next.node = q[7:0];
                        end
                    end else if (a == HR_BURST_MODE - HR_BASE) begin
                        if (q < MODE_MIN || q > MODE_MAX) begin
                            s_next.exc = EXC_VALUE;
                        end else if (s_reg.key == SAVE_KEY) begin
                            s_next.mode = q[1:0];
                        end
                    end else if (a == HR_SAVE_KEY - HR_BASE) begin
                        s_next.key = q;
                    end else begin
                        s_next.exc = EXC_ADDR;
                    end
                end else begin
                    // Multiple writes and all else refused
                    s_next.exc = EXC_FUNC;
                end
                if (s_next.exc != 8'h00) begin
                    s_next.len = 8'h03;
                end
                s_next.tx_valid = (s_next.st == S_SEND);
                s_next.tx_data  = s_reg.rxb[0];
                s_next.tx_last  = 1'b0;
            end
            S_SEND: begin
                if (tx_ready) begin
                    if (s_reg.tx_last) begin
                        s_next.tx_valid = 1'b0;
                        s_next.tx_last  = 1'b0;
                        s_next.st       = S_IDLE;
                    end else begin
                        s_next.idx     = s_reg.idx + 8'h01;
                        s_next.tx_data = resp_byte(s_reg,
                                                   s_reg.idx + 8'h01);
                        s_next.tx_last = (s_reg.idx + 8'h02 == s_reg.len);
                    end
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            s_reg      <= '0;
            s_reg.node <= NODE_RST;
            s_reg.mode <= MODE_RST;
            s_reg.key  <= KEY_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    assign tx_valid   = s_reg.tx_valid;
    assign tx_data    = s_reg.tx_data;
    assign tx_last    = s_reg.tx_last;
    assign low_power  = s_reg.low_power;
    assign burst_mode = s_reg.mode;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    logic [TMR_W-1:0] idle_cyc;

    // Cycles since the last received frame
    always_ff @(posedge clk) begin
        if (srst || frame_end || !s_reg.booted) begin
            idle_cyc <= '0;
        end else if (idle_cyc != '1) begin
            idle_cyc <= idle_cyc + 1'b1;
        end
    end

    property p_sleep1;
        @(posedge clk) disable iff (srst)
        $rose(s_reg.low_power) && s_reg.mode == 2'h1 && s_reg.booted
            |-> idle_cyc == SLEEP1_CYC + 1'b1;
    endproperty
    a_sleep1: assert property (p_sleep1)
        else $error("sleep after wrong idle time, mode 1");

    property p_sleep2;
        @(posedge clk) disable iff (srst)
        $rose(s_reg.low_power) && s_reg.mode == 2'h2
            |-> idle_cyc == SLEEP2_CYC + 1'b1;
    endproperty
    a_sleep2: assert property (p_sleep2)
        else $error("sleep after wrong idle time, mode 2");

    property p_sleep3;
        @(posedge clk) disable iff (srst)
        $rose(s_reg.low_power) && s_reg.mode == 2'h3
            |-> idle_cyc == SLEEP3_CYC + 1'b1;
    endproperty
    a_sleep3: assert property (p_sleep3)
        else $error("sleep after wrong idle time, mode 3");

    property p_save;
        @(posedge clk) disable iff (srst)
        $rose(s_reg.low_power) |-> s_reg.saved == $past(s_reg.live);
    endproperty
    a_save: assert property (p_save)
        else $error("results not saved on entering low power");

    property p_wake_stale;
        @(posedge clk) disable iff (srst)
        frame_end && s_reg.low_power
            |=> !s_reg.low_power && s_reg.stale;
    endproperty
    a_wake_stale: assert property (p_wake_stale)
        else $error("wake frame not served from saved results");

    property p_node_range;
        @(posedge clk) disable iff (srst)
        s_reg.node >= NODE_MIN[7:0] && s_reg.node <= NODE_MAX[7:0];
    endproperty
    a_node_range: assert property (p_node_range)
        else $error("node address out of range");

    property p_locked;
        @(posedge clk) disable iff (srst)
        $changed(s_reg.node) || $changed(s_reg.mode)
            |-> $past(s_reg.key) == SAVE_KEY;
    endproperty
    a_locked: assert property (p_locked)
        else $error("configuration changed without key");

    property p_bad_func;
        @(posedge clk) disable iff (srst)
        s_reg.st == S_EVAL && s_reg.rxb[0] == s_reg.node &&
        s_reg.rxb[1] == FN_WR_MULTI
            |=> s_reg.exc == EXC_FUNC && s_reg.len == 8'h03 && tx_valid;
    endproperty
    a_bad_func: assert property (p_bad_func)
        else $error("function 16 not refused");
endmodule

// [rtl/msrp_timer.sv]
// Loadable down counter that pulses once when it runs out
`timescale 1ns/1ns
module msrp_timer #(
    parameter int W = 34
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         srst,
    // Control
    input  wire logic         start,
    input  wire logic [W-1:0] load,
    // Result
    output logic              expire
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         expire;
    } msrp_tmr_t;

    msrp_tmr_t t_reg;
    msrp_tmr_t t_next;

    // Reload on start, count down otherwise, pulse on the last step
    always_comb begin
        t_next        = t_reg;
        t_next.expire = 1'b0;
        if (start) begin
            t_next.cnt = load;
        end else if (t_reg.cnt != '0) begin
            t_next.cnt    = t_reg.cnt - 1'b1;
            t_next.expire = (t_reg.cnt == W'(1));
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            t_reg <= '0;
        end else begin
            t_reg <= t_next;
        end
    end

    assign expire = t_reg.expire;
endmodule

// [tb/msrp_master.sv]
// Modbus master model that sends request frames and gathers answers
`timescale 1ns/1ns
module msrp_master (
    // Clock
    input  wire logic       clk,
    // Request bytes to the port
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_last,
    // Answer bytes from the port
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_last,
    output logic            tx_ready
);
    logic [7:0] ans[$];
    time        t_end;
    // Idle levels at time zero
    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        rx_last  = 1'b0;
        tx_ready = 1'b1;
    end
    // One request, then the answer with a stall on every other cycle
    task automatic xfer(input logic [7:0] fr[$]);
        int n;
        ans.delete();
        foreach (fr[i]) begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_data  <= fr[i];
            rx_last  <= (i == fr.size() - 1);
        end
        @(posedge clk);
        t_end = $time;
        rx_valid <= 1'b0;
        rx_last  <= 1'b0;
        rx_data  <= ~fr[fr.size() - 1]; // Released line shows no stale byte
        for (n = 0; n < 200; n++) begin
            @(negedge clk);
            if (tx_valid === 1'b1 && tx_ready) begin
                ans.push_back(tx_data);
                if (tx_last === 1'b1)
                    break;
            end
            @(posedge clk);
            tx_ready <= ~tx_ready;
        end
        // Let the last byte be taken and tx_valid fall
        @(posedge clk);
        @(posedge clk);
        tx_ready <= 1'b1;
    endtask
endmodule

// [tb/msrp_port_tb_top.sv]
// Self-checking bench of the sensor register port
`timescale 1ns/1ns
module msrp_port_tb_top;
    import msrp_pkg::*;
    localparam int S[4] = '{0, 200, 500, 500};
    localparam int W[4] = '{0, 40, 60, 50};
    logic        clk       = 1'b0;
    logic        srst      = 1'b1;
    logic        meas_wr   = 1'b0;
    logic [2:0]  meas_idx  = 3'h0;
    logic [31:0] meas_data = 32'h0;
    logic        rx_valid, rx_last, tx_valid, tx_last, tx_ready;
    logic [7:0]  rx_data, tx_data;
    logic        low_power;
    logic [1:0]  burst_mode;
    logic [31:0] vals[7];
    int          num_errors  = 0;
    int          checks_done = 0;
    // 50 MHz clock
    always #10 clk = ~clk;
    msrp_port #(
        .SLEEP1_CYC(TMR_W'(S[1])), .SLEEP2_CYC(TMR_W'(S[2])),
        .SLEEP3_CYC(TMR_W'(S[3])), .WAKE1_CYC(TMR_W'(W[1])),
        .WAKE2_CYC(TMR_W'(W[2])), .WAKE3_CYC(TMR_W'(W[3]))
    ) uut (
        .clk(clk), .srst(srst), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_last(rx_last), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_last(tx_last), .tx_ready(tx_ready), .meas_wr(meas_wr),
        .meas_idx(meas_idx), .meas_data(meas_data),
        .low_power(low_power), .burst_mode(burst_mode)
    );
    msrp_master m (
        .clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_last(rx_last), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_last(tx_last), .tx_ready(tx_ready)
    );
    // Verdict and end of run
    task automatic wrap_up;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Compare one value
    task automatic chk(input logic [31:0] got, exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s %0h not %0h", $time, msg,
                     got, exp);
        end
    endtask
    // Send a frame and compare the whole answer
    task automatic run(input logic [7:0] fr[$], input logic [7:0] e[$]);
        m.xfer(fr);
        chk(32'(m.ans.size()), 32'(e.size()), "answer length");
        foreach (e[i]) chk(32'(m.ans[i]), 32'(e[i]), "answer byte");
    endtask
    // Result word from the measurement engine
    task automatic put(input logic [2:0] k, input logic [31:0] d);
        @(posedge clk);
        meas_wr   <= 1'b1;
        meas_idx  <= k;
        meas_data <= d;
        @(posedge clk);
        meas_wr <= 1'b0;
    endtask
    // Input register read, expected words high half first
    task automatic rd4(input int w, q);
        logic [7:0]  e[$];
        logic [15:0] wd;
        e = '{8'h01, 8'h04, 8'(2 * q)};
        for (int k = w; k < w + q; k++) begin
            wd = k[0] ? vals[k / 2][15:0] : vals[k / 2][31:16];
            e.push_back(wd[15:8]);
            e.push_back(wd[7:0]);
        end
        run('{8'h01, 8'h04, 8'h00, 8'(w), 8'h00, 8'(q)}, e);
    endtask
    // Holding register single write, answered by an echo
    task automatic wr(input logic [7:0] r, input logic [15:0] v);
        run('{8'h01, 8'h06, 8'h00, r, v[15:8], v[7:0]},
            '{8'h01, 8'h06, 8'h00, r, v[15:8], v[7:0]});
    endtask
    // Cycles from the last frame end until low-power
    task automatic sleep_chk(input int s);
        for (int n = 0; n < 2000 && low_power !== 1'b1; n++)
            @(negedge clk);
        chk(32'(($time - m.t_end - 10) / 20), 32'(s + 1), "sleep delay");
    endtask
    task automatic t_read;
        rd4(0, 14);
        rd4(3, 3);
        run('{8'h01, 8'h04, 8'h00, 8'h0D, 8'h00, 8'h02},
            '{8'h01, 8'h84, 8'h02});
    endtask
    task automatic t_func;
        run('{8'h01, 8'h10, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00,
              8'h05}, '{8'h01, 8'h90, 8'h01});
        run('{8'h01, 8'h05, 8'h00, 8'h00, 8'hFF, 8'h00},
            '{8'h01, 8'h85, 8'h01});
    endtask
    task automatic t_cfg;
        wr(8'h01, 16'h0002);
        chk(32'(burst_mode), 32'h1, "locked mode");
        wr(8'h02, SAVE_KEY);
        wr(8'h01, 16'h0002);
        chk(32'(burst_mode), 32'h2, "mode");
        run('{8'h01, 8'h06, 8'h00, 8'h01, 8'h00, 8'h04},
            '{8'h01, 8'h86, 8'h03});
        run('{8'h01, 8'h06, 8'h00, 8'h00, 8'h00, 8'hF8},
            '{8'h01, 8'h86, 8'h03});
        run('{8'h01, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00},
            '{8'h01, 8'h86, 8'h03});
        wr(8'h00, 16'h0001);
        run('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h03},
            '{8'h01, 8'h03, 8'h06, 8'h00, 8'h01, 8'h00, 8'h02, 8'h15,
              8'hB3});
    endtask
    task automatic t_err;
        put(3'h6, 32'hDEAD0000);
        rd4(12, 2);
    endtask
    task automatic t_sleep;
        sleep_chk(S[2]);
        wr(8'h01, 16'h0003);
        chk(32'(low_power), 32'h0, "woken");
        sleep_chk(S[3]);
        wr(8'h01, 16'h0001);
        repeat (100) @(posedge clk);
        rd4(0, 2);
        sleep_chk(S[1]);
    endtask
    task automatic t_saved;
        put(3'h0, 32'h01234567);
        rd4(0, 2);
        chk(32'(low_power), 32'h0, "woken");
        vals[0] = 32'h01234567;
        repeat (W[1] + 5) @(posedge clk);
        rd4(0, 2);
    endtask
    // Watchdog against a hang
    initial begin
        #200000;
        num_errors++;
        wrap_up();
    end
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            vals[i] = 32'hA1B2C3D0 + i;
            put(3'(i), vals[i]);
        end
        t_read();
        t_func();
        t_cfg();
        t_err();
        t_sleep();
        t_saved();
        wrap_up();
    end
endmodule
